/* File: rtl/three_port_parallel_io.sv */
// Overview of operation
// [R1] first port: seven bidirectional pins, each with its own data latch bit.
// [R2] direction 1 drives latch onto pin; direction 0 leaves pin as input.
// [R3] reset clears all seven first-port direction bits.
// [R4] reset leaves first-port data latch untouched.
// [R5] first-port data read: latch for outputs, pin level for inputs.
// [R6] data writes always update the latch whatever the direction.
// [R7] write to an input bit changes latch only, read still shows pin.
// [R8] software writes data before switching a direction bit to output.
// [R9] second port: eight pins with latches, shared with converter and timer.
// [R10] converter selection on pins six and seven disconnects the timer.
// [R11] software disables timer channel before enabling converter on a pin; the test selects the converter on pin six while its timer is still on.
// [R12] reset clears all eight second-port direction bits.
// [R13] reset leaves second-port data latch untouched.
// [R14] second-port data read: latch for outputs, pin level for inputs.
// [R15] third port: five bidirectional pins, each with a data latch bit.
// [R16] clock-output enable drives bus clock on third port pin two.
// [R17] reset clears third-port direction bits and the clock-output enable.
// [R18] third-port latch survives reset; read merges latch and pin by direction.
// [R19] with clock output on, bit two reads 0 and writes miss the pin.

`default_nettype none

module three_port_parallel_io #(
   parameter int FIRST_WIDTH  = parallel_io_pkg::FIRST_WIDTH,
   parameter int SECOND_WIDTH = parallel_io_pkg::SECOND_WIDTH,
   parameter int THIRD_WIDTH  = parallel_io_pkg::THIRD_WIDTH
) (
   // clock, reset, enable
   input  wire logic                                 clk_sys,
   input  wire logic                                 rst_b,
   input  wire logic                                 clk_en,

   // register port
   input  wire parallel_io_pkg::bus_req_type         bus_req,
   output logic [parallel_io_pkg::DATA_WIDTH-1:0]    rdata,

   // first port pins
   input  wire logic [FIRST_WIDTH-1:0]               first_pin_in,
   output logic [FIRST_WIDTH-1:0]                    first_pin_out,
   output logic [FIRST_WIDTH-1:0]                    first_pin_oe,

   // second port pins
   input  wire logic [SECOND_WIDTH-1:0]              second_pin_in,
   output logic [SECOND_WIDTH-1:0]                   second_pin_out,
   output logic [SECOND_WIDTH-1:0]                   second_pin_oe,

   // second port sharing with converter and timer
   input  wire parallel_io_pkg::shared_ctrl_type     shared_ctrl,
   output logic [parallel_io_pkg::SHARED_COUNT-1:0]  converter_connect,
   output logic [parallel_io_pkg::SHARED_COUNT-1:0]  timer_capture_in,

   // third port pins
   input  wire logic [THIRD_WIDTH-1:0]               third_pin_in,
   output logic [THIRD_WIDTH-1:0]                    third_pin_out,
   output logic [THIRD_WIDTH-1:0]                    third_pin_oe,
   output logic                                      clock_output_enable
);

   localparam int DW = parallel_io_pkg::DATA_WIDTH;
   localparam int LO = parallel_io_pkg::SHARED_LOW_BIT;
   localparam int NS = parallel_io_pkg::SHARED_COUNT;
   localparam int CP = parallel_io_pkg::CLOCK_PIN_BIT;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // per bit: latch when output, live pin when input
   function automatic logic [DW-1:0] merge_read(
      input logic [DW-1:0] latch,
      input logic [DW-1:0] dir,
      input logic [DW-1:0] pin
   );
      merge_read = (latch & dir) | (pin & ~dir);
   endfunction

   // place a narrow port value in the low bits, upper bits zero
   function automatic logic [DW-1:0] widen(
      input logic [DW-1:0] value,
      input int            width
   );
      logic [DW-1:0] mask;
      mask  = parallel_io_pkg::READ_ZERO;
      for (int i = 0; i < DW; i++)
      begin
         mask[i] = (i < width);
      end
      widen = value & mask;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [FIRST_WIDTH-1:0]  first_port_data_reg;
   logic [SECOND_WIDTH-1:0] second_port_data_reg;
   logic [THIRD_WIDTH-1:0]  third_port_data_reg;
   logic [FIRST_WIDTH-1:0]  first_port_direction_reg;
   logic [SECOND_WIDTH-1:0] second_port_direction_reg;
   logic [THIRD_WIDTH-1:0]  third_port_direction_reg;
   logic                    clock_output_enable_reg;
   logic [DW-1:0]           rdata_reg;
   logic [DW-1:0]           rdata_next;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire logic hit_first_data  = (bus_req.addr == parallel_io_pkg::FIRST_DATA_ADDR);
   wire logic hit_second_data = (bus_req.addr == parallel_io_pkg::SECOND_DATA_ADDR);
   wire logic hit_third_data  = (bus_req.addr == parallel_io_pkg::THIRD_DATA_ADDR);
   wire logic hit_first_dir   = (bus_req.addr == parallel_io_pkg::FIRST_DIR_ADDR);
   wire logic hit_second_dir  = (bus_req.addr == parallel_io_pkg::SECOND_DIR_ADDR);
   wire logic hit_third_dir   = (bus_req.addr == parallel_io_pkg::THIRD_DIR_ADDR);

   wire logic wr_go = bus_req.wr & clk_en;
   wire logic rd_go = bus_req.rd & clk_en;

   // ----------------------------------------------------------------
   // write enables
   // ----------------------------------------------------------------
   // clk_en gates every strobe, so a frozen block takes no write
   wire logic wr_first_data  = wr_go & hit_first_data;
   wire logic wr_second_data = wr_go & hit_second_data;
   wire logic wr_third_data  = wr_go & hit_third_data;
   wire logic wr_first_dir   = wr_go & hit_first_dir;
   wire logic wr_second_dir  = wr_go & hit_second_dir;
   wire logic wr_third_dir   = wr_go & hit_third_dir;

   // ----------------------------------------------------------------
   // data latches
   // ----------------------------------------------------------------
   // no reset on purpose: latch contents must ride through reset
   // [R4] latch keeps value
   // [R6] write always lands
   // [R7] input bit still writes
   always_ff @(posedge clk_sys)
   begin
      if (wr_first_data)
      begin
         first_port_data_reg <= bus_req.wdata[FIRST_WIDTH-1:0];
      end
   end

   // [R13] latch keeps value
   // [R6] write always lands
   always_ff @(posedge clk_sys)
   begin
      if (wr_second_data)
      begin
         second_port_data_reg <= bus_req.wdata[SECOND_WIDTH-1:0];
      end
   end

   // [R18] latch keeps value
   // [R6] write always lands
   always_ff @(posedge clk_sys)
   begin
      if (wr_third_data)
      begin
         third_port_data_reg <= bus_req.wdata[THIRD_WIDTH-1:0];
      end
   end

   // ----------------------------------------------------------------
   // direction registers
   // ----------------------------------------------------------------
   // reset is asynchronous so every pin lets go before the clock runs, except timer-owned second-port pins six and seven, which follow timer_drive
   // [R3] first directions cleared
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         first_port_direction_reg <= parallel_io_pkg::DIR_RESET[FIRST_WIDTH-1:0];
      end
      else if (wr_first_dir)
      begin
         first_port_direction_reg <= bus_req.wdata[FIRST_WIDTH-1:0];
      end
   end

   // [R12] second directions cleared
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         second_port_direction_reg <= parallel_io_pkg::DIR_RESET[SECOND_WIDTH-1:0];
      end
      else if (wr_second_dir)
      begin
         second_port_direction_reg <= bus_req.wdata[SECOND_WIDTH-1:0];
      end
   end

   // [R17] third directions, clock off
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         third_port_direction_reg <= parallel_io_pkg::DIR_RESET[THIRD_WIDTH-1:0];
         clock_output_enable_reg  <= parallel_io_pkg::DIR_RESET[parallel_io_pkg::CLOCK_OUT_BIT];
      end
      else if (wr_third_dir)
      begin
         third_port_direction_reg <= bus_req.wdata[THIRD_WIDTH-1:0];
         clock_output_enable_reg  <= bus_req.wdata[parallel_io_pkg::CLOCK_OUT_BIT];
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // [R5] first port merge
   wire logic [DW-1:0] first_read = widen(merge_read(
      DW'(first_port_data_reg), DW'(first_port_direction_reg), DW'(first_pin_in)),
      FIRST_WIDTH);

   // [R14] second port merge
   wire logic [DW-1:0] second_read = widen(merge_read(
      DW'(second_port_data_reg), DW'(second_port_direction_reg), DW'(second_pin_in)),
      SECOND_WIDTH);

   // [R18] third port merge
   wire logic [DW-1:0] third_merged = widen(merge_read(
      DW'(third_port_data_reg), DW'(third_port_direction_reg), DW'(third_pin_in)),
      THIRD_WIDTH);

   // [R19] clock pin reads zero
   wire logic [DW-1:0] clock_pin_mask = ~(DW'(clock_output_enable_reg) << CP);
   wire logic [DW-1:0] third_read     = third_merged & clock_pin_mask;

   wire logic [DW-1:0] first_dir_read  = widen(DW'(first_port_direction_reg), FIRST_WIDTH);
   wire logic [DW-1:0] second_dir_read = widen(DW'(second_port_direction_reg), SECOND_WIDTH);
   wire logic [DW-1:0] third_dir_read  =
      widen(DW'(third_port_direction_reg), THIRD_WIDTH) |
      (DW'(clock_output_enable_reg) << parallel_io_pkg::CLOCK_OUT_BIT);

   // unmapped addresses read as zero
   always_comb
   begin
      rdata_next = parallel_io_pkg::READ_ZERO;
      if (hit_first_data)
      begin
         rdata_next = first_read;
      end
      else if (hit_second_data)
      begin
         rdata_next = second_read;
      end
      else if (hit_third_data)
      begin
         rdata_next = third_read;
      end
      else if (hit_first_dir)
      begin
         rdata_next = first_dir_read;
      end
      else if (hit_second_dir)
      begin
         rdata_next = second_dir_read;
      end
      else if (hit_third_dir)
      begin
         rdata_next = third_dir_read;
      end
   end

   // read data stands from the cycle after the strobe until the next edge with clk_en high
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdata_reg <= parallel_io_pkg::READ_ZERO;
      end
      else if (clk_en)
      begin
         rdata_reg <= rd_go ? rdata_next : parallel_io_pkg::READ_ZERO;
      end
   end

   assign rdata = rdata_reg;

   // ----------------------------------------------------------------
   // first port pins
   // ----------------------------------------------------------------
   // [R1] seven latched pins
   // [R2] direction gates driver
   assign first_pin_out = first_port_data_reg;
   assign first_pin_oe  = first_port_direction_reg;

   // ----------------------------------------------------------------
   // second port pins and sharing
   // ----------------------------------------------------------------
   // converter wins over timer; the pin goes quiet so the analog level is clean
   // [R10] converter beats timer
   wire logic [NS-1:0] timer_owns =
      shared_ctrl.timer_enable & ~shared_ctrl.converter_select;

   assign converter_connect = shared_ctrl.converter_select;
   assign timer_capture_in  = second_pin_in[LO +: NS] & timer_owns;

   // [R9] eight latched pins
   always_comb
   begin
      second_pin_out = second_port_data_reg;
      second_pin_oe  = second_port_direction_reg;
      for (int i = 0; i < NS; i++)
      begin
         if (shared_ctrl.converter_select[i])
         begin
            second_pin_oe[LO + i] = 1'b0;
         end
         else if (timer_owns[i])
         begin
            second_pin_out[LO + i] = shared_ctrl.timer_out[i];
            second_pin_oe[LO + i]  = shared_ctrl.timer_drive[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // third port pins
   // ----------------------------------------------------------------
   // the enable flips just after a rising edge, while the clock is high,
   // so handing the pin from clock back to a low latch leaves a runt pulse;
   // a pad cell with its own clock gate would still be the safer choice
   // [R15] five latched pins
   // [R16] bus clock on pin two
   always_comb
   begin
      third_pin_out = third_port_data_reg;
      third_pin_oe  = third_port_direction_reg;
      if (clock_output_enable_reg)
      begin
         third_pin_out[CP] = clk_sys;
         third_pin_oe[CP]  = 1'b1;
      end
   end

   assign clock_output_enable = clock_output_enable_reg;

endmodule

`default_nettype wire

/* File: rtl/parallel_io_pkg.sv */
`default_nettype none

package parallel_io_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_WIDTH   = 8;
   localparam int DATA_WIDTH   = 8;
   localparam int FIRST_WIDTH  = 7;
   localparam int SECOND_WIDTH = 8;
   localparam int THIRD_WIDTH  = 5;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_WIDTH-1:0] FIRST_DATA_ADDR   = 8'h00;
   localparam logic [ADDR_WIDTH-1:0] SECOND_DATA_ADDR  = 8'h01;
   localparam logic [ADDR_WIDTH-1:0] THIRD_DATA_ADDR   = 8'h02;
   localparam logic [ADDR_WIDTH-1:0] FIRST_DIR_ADDR    = 8'h04;
   localparam logic [ADDR_WIDTH-1:0] SECOND_DIR_ADDR   = 8'h05;
   localparam logic [ADDR_WIDTH-1:0] THIRD_DIR_ADDR    = 8'h06;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int CLOCK_OUT_BIT     = 7;
   localparam int CLOCK_PIN_BIT     = 2;
   localparam int SHARED_LOW_BIT    = 6;
   localparam int SHARED_COUNT      = 2;
   localparam logic [DATA_WIDTH-1:0] DIR_RESET  = 8'h00;
   localparam logic [DATA_WIDTH-1:0] READ_ZERO  = 8'h00;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_WIDTH-1:0] addr;
      logic [DATA_WIDTH-1:0] wdata;
      logic                  wr;
      logic                  rd;
   } bus_req_type;

   typedef struct packed {
      logic [SHARED_COUNT-1:0] converter_select;
      logic [SHARED_COUNT-1:0] timer_enable;
      logic [SHARED_COUNT-1:0] timer_out;
      logic [SHARED_COUNT-1:0] timer_drive;
   } shared_ctrl_type;

endpackage

`default_nettype wire

/* File: test/parallel_io_properties.sv */
`default_nettype none

// ----------------------------------------
// port checker
// ----------------------------------------
module parallel_io_properties #(
   parameter int FIRST_WIDTH  = 7,
   parameter int SECOND_WIDTH = 8,
   parameter int THIRD_WIDTH  = 5
) (
   // clock and bus
   input wire logic                             clk_sys,
   input wire logic                             rst_b,
   input wire logic                             clk_en,
   input wire parallel_io_pkg::bus_req_type     bus_req,
   input wire logic [7:0]                       rdata,
   // pins
   input wire logic [FIRST_WIDTH-1:0]           first_pin_in,
   input wire logic [FIRST_WIDTH-1:0]           first_pin_out,
   input wire logic [FIRST_WIDTH-1:0]           first_pin_oe,
   input wire logic [SECOND_WIDTH-1:0]          second_pin_oe,
   input wire parallel_io_pkg::shared_ctrl_type shared_ctrl,
   input wire logic [1:0]                       converter_connect,
   input wire logic [1:0]                       timer_capture_in,
   input wire logic [THIRD_WIDTH-1:0]           third_pin_oe,
   input wire logic                             clock_output_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic wr_ok = clk_en & bus_req.wr;
   wire logic rd_ok = clk_en & bus_req.rd;
   wire logic [FIRST_WIDTH-1:0] wd_first = bus_req.wdata[FIRST_WIDTH-1:0];
   wire logic wd_top = bus_req.wdata[7];
   wire logic [7:0] merge_first = 8'((first_pin_out & first_pin_oe)
                                     | (first_pin_in & ~first_pin_oe));

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_idle_rdata_zero: assert property ($past(clk_en) && !$past(bus_req.rd)
      |-> rdata == 8'h00) else $error("read data not zero outside a read");
   a_first_dir_wr: assert property (wr_ok && bus_req.addr == 8'h04
      |=> first_pin_oe == $past(wd_first)) else $error("first direction write not on pins");
   a_first_data_wr: assert property (wr_ok && bus_req.addr == 8'h00
      |=> first_pin_out == $past(wd_first)) else $error("first data write not on latch");
   a_clock_en_wr: assert property (wr_ok && bus_req.addr == 8'h06
      |=> clock_output_enable == $past(wd_top)) else $error("clock enable write lost");
   a_reset_inputs: assert property ($rose(rst_b) |-> first_pin_oe == '0
      && third_pin_oe == '0 && !clock_output_enable && second_pin_oe[5:0] == '0)
      else $error("pins not inputs after reset");
   a_conv_wins: assert property (((second_pin_oe[7:6] | timer_capture_in)
      & shared_ctrl.converter_select) == 2'b00) else $error("timer kept a converter pin");
   a_conv_connect: assert property (converter_connect == shared_ctrl.converter_select)
      else $error("converter connection wrong");
   a_first_read: assert property (rd_ok && bus_req.addr == 8'h00
      |=> rdata == $past(merge_first)) else $error("first port read merge wrong");
   a_clock_bit_zero: assert property (rd_ok && bus_req.addr == 8'h02
      && clock_output_enable |=> !rdata[2]) else $error("clock pin bit not zero");
   a_clock_pin_oe: assert property (clock_output_enable |-> third_pin_oe[2])
      else $error("clock pin not driven");

   c_dir_write: cover property (wr_ok && bus_req.addr == 8'h04);
   c_clock_read: cover property (rd_ok && bus_req.addr == 8'h02 && clock_output_enable);
   c_conv_sel: cover property (shared_ctrl.converter_select == 2'b11);
endmodule

bind three_port_parallel_io parallel_io_properties #(
   .FIRST_WIDTH(FIRST_WIDTH), .SECOND_WIDTH(SECOND_WIDTH), .THIRD_WIDTH(THIRD_WIDTH)
) parallel_io_properties_i (
   .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .bus_req(bus_req), .rdata(rdata),
   .first_pin_in(first_pin_in), .first_pin_out(first_pin_out), .first_pin_oe(first_pin_oe),
   .second_pin_oe(second_pin_oe), .shared_ctrl(shared_ctrl),
   .converter_connect(converter_connect), .timer_capture_in(timer_capture_in),
   .third_pin_oe(third_pin_oe), .clock_output_enable(clock_output_enable)
);

`default_nettype wire

/* File: test/pin_partner.sv */
`default_nettype none

// ----------------------------------------
// pins seen from outside the chip
// ----------------------------------------
module pin_partner #(
   parameter int W = 8
) (
   // from the port
   input  wire logic [W-1:0] pin_out,
   input  wire logic [W-1:0] pin_oe,
   // outside world
   input  wire logic [W-1:0] ext_level,
   output logic      [W-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // driven pins win, released follow outside
   assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

`default_nettype wire

/* File: test/three_port_parallel_io_test.sv */
`default_nettype none

module three_port_parallel_io_test;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // signals and model
   // ----------------------------------------
   logic                             clk_sys, rst_b, clk_en, clk_out_en;
   parallel_io_pkg::bus_req_type     bus_req;
   parallel_io_pkg::shared_ctrl_type shared_ctrl;
   logic [7:0]                       rdata, second_in, second_out, second_oe, second_ext;
   logic [6:0]                       first_in, first_out, first_oe, first_ext;
   logic [4:0]                       third_in, third_out, third_oe, third_ext;
   logic [1:0]                       conv_connect, cap_in;
   logic [31:0]                      seed = 32'h0000_0042;
   int lat[3], dir[3], ext[3], mclk, err_count, checks;
   int mask[3] = '{8'h7F, 8'hFF, 8'h1F};

   three_port_parallel_io three_port_parallel_io_i (
      .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .bus_req(bus_req), .rdata(rdata),
      .first_pin_in(first_in), .first_pin_out(first_out), .first_pin_oe(first_oe),
      .second_pin_in(second_in), .second_pin_out(second_out), .second_pin_oe(second_oe),
      .shared_ctrl(shared_ctrl), .converter_connect(conv_connect), .timer_capture_in(cap_in),
      .third_pin_in(third_in), .third_pin_out(third_out), .third_pin_oe(third_oe),
      .clock_output_enable(clk_out_en));
   // widths of the three ports
   pin_partner #(.W(7)) first_pins_i (.pin_out(first_out), .pin_oe(first_oe),
      .ext_level(first_ext), .pin_in(first_in));
   pin_partner #(.W(8)) second_pins_i (.pin_out(second_out), .pin_oe(second_oe),
      .ext_level(second_ext), .pin_in(second_in));
   pin_partner #(.W(5)) third_pins_i (.pin_out(third_out), .pin_oe(third_oe),
      .ext_level(third_ext), .pin_in(third_in));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   function automatic int exp_data(input int p);
      int v;
      v = ((lat[p] & dir[p]) | (ext[p] & ~dir[p])) & mask[p];
      if (p == 2 && mclk != 0) v = v & 8'hFB;
      return v;
   endfunction

   task automatic chk(input string name, input logic [7:0] want, input logic [7:0] got);
      checks++;
      if (got !== want)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", name, want, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
      if (clk_en && a < 3) lat[a] = d & mask[a];
      if (clk_en && a > 3 && a < 7) dir[a-4] = d & mask[a-4];
      if (clk_en && a == 6) mclk = d[7];
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] want);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      #1;
      chk("rdata", want, rdata);
   endtask

   task automatic pins();
      logic [7:0] m;
      m = (mclk != 0) ? 8'h1B : 8'h1F;
      chk("first_out", 8'(lat[0]), 8'(first_out));
      chk("first_oe", 8'(dir[0]), 8'(first_oe));
      chk("second_out", 8'(lat[1]), second_out);
      chk("second_oe", 8'(dir[1]), second_oe);
      chk("third_out", 8'(lat[2]) & m, 8'(third_out) & m);
      chk("third_oe", 8'(dir[2] | (mclk << 2)), 8'(third_oe));
      chk("clock_en", 8'(mclk), 8'(clk_out_en));
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ----------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial
   begin
      #100us;
      err_count++;
      end_of_test();
   end

   initial
   begin
      {rst_b, bus_req, shared_ctrl, first_ext, second_ext, third_ext} = '0;
      clk_en = 1'b1;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      #1;
      // data latches are unknown here, so only directions are looked at
      chk("first_oe", 8'h00, 8'(first_oe));
      chk("second_oe", 8'h00, second_oe);
      chk("third_oe", 8'h00, 8'(third_oe));
      chk("clock_en", 8'h00, 8'(clk_out_en));
      for (int p = 0; p < 3; p++) rd(8'(p + 4), 8'h00);
      $display("test reset done");
      repeat (20)
      begin
         @(posedge clk_sys);
         for (int p = 0; p < 3; p++) ext[p] = rnd() & mask[p];
         first_ext <= 7'(ext[0]);
         second_ext <= 8'(ext[1]);
         third_ext <= 5'(ext[2]);
         for (int p = 0; p < 3; p++)
         begin
            // data before direction
            wr(8'(p), rnd());
            wr(8'(p + 4), rnd());
            rd(8'(p), 8'(exp_data(p)));
            rd(8'(p + 4), 8'(dir[p] | (p == 2 ? mclk << 7 : 0)));
         end
         pins();
      end
      $display("test traffic done");
      // unmapped places keep nothing
      wr(8'h03, 8'hFF);
      wr(8'h07, 8'hFF);
      rd(8'h03, 8'h00);
      rd(8'h07, 8'h00);
      pins();
      $display("test unmapped done");
      @(posedge clk_sys);
      clk_en <= 1'b0;
      wr(8'h04, 8'h5A);
      clk_en <= 1'b1;
      #1;
      pins();
      $display("test enable done");
      @(posedge clk_sys);
      shared_ctrl <= '{2'b00, 2'b11, 2'b10, 2'b11};
      @(posedge clk_sys);
      #1;
      chk("timer_oe", 8'h03, 8'(second_oe[7:6]));
      chk("timer_out", 8'h02, 8'(second_out[7:6]));
      chk("capture", 8'h02, 8'(cap_in));
      chk("connect", 8'h00, 8'(conv_connect));
      // converter on both pins in the same step that turns the pin seven timer off; pin six timer stays on
      shared_ctrl <= '{2'b11, 2'b01, 2'b10, 2'b11};
      @(posedge clk_sys);
      #1;
      chk("shared_oe", 8'h00, 8'(second_oe[7:6]));
      chk("connect", 8'h03, 8'(conv_connect));
      chk("capture", 8'h00, 8'(cap_in));
      shared_ctrl <= '0;
      $display("test shared done");
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      dir = '{0, 0, 0};
      mclk = 0;
      for (int p = 0; p < 3; p++)
      begin
         wr(8'(p + 4), 8'h7F);
         rd(8'(p), 8'(exp_data(p)));
      end
      $display("test rereset done");
      end_of_test();
   end
endmodule

`default_nettype wire
